/* File: rtl/ssp_core.sv */
// Synchronous serial port: register file, master and slave shift engine, status flags.
`timescale 1ns/1ps

module ssp_core (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Register port.
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [7:0] rdData,
    // CPU interrupt mask and interrupt request.
    input wire logic cpuIrqMask,
    output logic irqReq,
    // Serial pins.
    input wire ssp_pkg::ssp_pin_in_s pinIn,
    output ssp_pkg::ssp_pin_out_s pinOut
);
    import ssp_pkg::*;

    ssp_pin_in_s pinSync;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] rxBuf_reg;
    logic [7:0] sr_reg;
    logic [7:0] sr_next;
    logic [7:0] rdData_reg;
    logic [3:0] bitCnt_reg;
    logic [3:0] edgeCnt_reg;
    logic doneFlag_reg;
    logic write_collision_flag_reg;
    logic ovr_reg;
    logic mode_fault_flag_reg;
    logic sod_reg;
    logic ssm_reg;
    logic ssi_reg;
    logic armed_reg;
    logic modfArmed_reg;
    logic mBusy_reg;
    logic mSampleDly_reg;
    logic mDoneDly_reg;
    logic txOut_reg;
    logic txOut_next;
    logic sckOut_reg;
    logic sckPrev_reg;
    logic mOe_reg;
    logic mosiOe_reg;
    logic sOe_reg;
    logic irq_reg;
    logic tick;
    ssp_role_e role;

    ssp_sync #(
        .WIDTH($bits(ssp_pin_in_s))
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d(pinIn),
        .q(pinSync)
    );

    // Register decode.
    wire selData = (addr == SSP_DATA_OFS);
    wire selCtrl = (addr == SSP_CTRL_OFS);
    wire selStat = (addr == SSP_STAT_OFS);
    wire dataWr = wrStb && selData;
    wire dataRd = rdStb && selData;
    wire ctrlWr = wrStb && selCtrl;
    wire statWr = wrStb && selStat;
    wire statAcc = (wrStb || rdStb) && selStat;

    // Control fields.
    wire irqEn = ctrl_reg[SSP_CTRL_IRQ_EN];
    wire periphEn = ctrl_reg[SSP_CTRL_PERIPH_EN];
    wire masterSel = ctrl_reg[SSP_CTRL_MASTER];
    wire pol = ctrl_reg[SSP_CTRL_POL];
    wire pha = ctrl_reg[SSP_CTRL_PHA];
    wire [2:0] rateSel = {ctrl_reg[SSP_CTRL_RATE2], ctrl_reg[SSP_CTRL_RATE1],
                          ctrl_reg[SSP_CTRL_RATE0]};

    // Slave select seen by the block: soft level or the synchronised pin.
    wire ssEffN = ssm_reg ? ssi_reg : pinSync.ssN;

    assign role = !periphEn ? SSP_OFF : (masterSel ? SSP_MASTER : SSP_SLAVE);
    wire isMaster = (role == SSP_MASTER);
    wire isSlave = (role == SSP_SLAVE);
    wire modeFault = isMaster && !ssEffN;

    ssp_rate_div u_div (
        .clk(clk),
        .rstn(rstn),
        .run(mBusy_reg),
        .rateSel(rateSel),
        .tick(tick)
    );

    // Master edges: even counts are leading edges, odd counts trailing.
    wire mLead = !edgeCnt_reg[0];
    wire mSample = tick && (mLead ^ pha);
    wire mUpdate = tick && !(mLead ^ pha);
    wire mDone = tick && (edgeCnt_reg == SSP_LAST_EDGE);

    // Slave edges from the synchronised clock; an f/2 clock still gives one
    // sample per level, which is why the slave cannot go any faster.
    wire sActive = isSlave && !ssEffN;
    wire sEdge = (pinSync.sck != sckPrev_reg);
    wire sLead = sEdge && (pinSync.sck != pol);
    wire sTrail = sEdge && (pinSync.sck == pol);
    wire sSample = sActive && (pha ? sTrail : sLead);
    wire sUpdate = sActive && (pha ? sLead : sTrail);
    wire sDone = sSample && (bitCnt_reg == SSP_LAST_BIT);

    // The master takes its sample one cycle after its sampling edge, and ends the byte
    // one cycle late to match: returned data reach the logic two cycles late through
    // the pin synchroniser, which at the fastest rate is the whole half period.
    wire doSample = mSampleDly_reg || sSample;
    wire doUpdate = mUpdate || sUpdate;
    wire xferDone = mDoneDly_reg || sDone;
    wire rxIn = isMaster ? pinSync.miso : pinSync.mosi;
    wire [7:0] rxByte = {sr_reg[6:0], rxIn};
    wire idle = !mBusy_reg && !sActive;

    // Data writes: blocked, colliding or accepted.
    wire busy = mBusy_reg || mDoneDly_reg || (sActive && (bitCnt_reg != 4'h0));
    wire blocked = doneFlag_reg && !armed_reg;
    wire wcolSet = dataWr && !blocked && busy;
    wire load = dataWr && !blocked && !busy;
    wire mStart = load && isMaster && !modeFault;

    // Flag clearing sequence: status access while set, then a data read, or a data write in slave mode.
    wire clrSeq = armed_reg && (dataRd || (isSlave && dataWr));
    wire modfClr = modfArmed_reg && ctrlWr;

    wire [7:0] statView = {doneFlag_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg, 1'b0,
                           sod_reg, ssm_reg, ssi_reg};
    wire [7:0] rdMux = selData ? rxBuf_reg :
                       selCtrl ? ctrl_reg :
                       selStat ? statView : 8'h00;

    always_comb begin
        ctrl_next = ctrlWr ? wrData : ctrl_reg;
        if (modeFault) begin
            ctrl_next[SSP_CTRL_MASTER] = 1'b0;
            ctrl_next[SSP_CTRL_PERIPH_EN] = 1'b0;
        end
    end

    always_comb begin
        if (load) begin
            sr_next = wrData;
        end else if (doSample) begin
            sr_next = rxByte;
        end else begin
            sr_next = sr_reg;
        end
    end

    // The out bit follows the shifter's MSB on update edges and while idle,
    // so a phase 0 slave has its MSB on the line as soon as select falls.
    always_comb begin
        if (load) begin
            txOut_next = wrData[7];
        end else if (doUpdate || idle) begin
            txOut_next = sr_reg[7];
        end else begin
            txOut_next = txOut_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= SSP_CTRL_RESET;
            sod_reg <= SSP_STAT_RESET[SSP_STAT_SOD];
            ssm_reg <= SSP_STAT_RESET[SSP_STAT_SSM];
            ssi_reg <= SSP_STAT_RESET[SSP_STAT_SSI];
            rdData_reg <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            if (statWr) begin
                sod_reg <= wrData[SSP_STAT_SOD] & SSP_STAT_WR_MASK[SSP_STAT_SOD];
                ssm_reg <= wrData[SSP_STAT_SSM] & SSP_STAT_WR_MASK[SSP_STAT_SSM];
                ssi_reg <= wrData[SSP_STAT_SSI] & SSP_STAT_WR_MASK[SSP_STAT_SSI];
            end
            rdData_reg <= rdStb ? rdMux : 8'h00;
        end
    end

    // Shift engine.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sr_reg <= SSP_DATA_RESET;
            txOut_reg <= 1'b0;
            sckPrev_reg <= 1'b0;
            bitCnt_reg <= 4'h0;
            edgeCnt_reg <= 4'h0;
            mBusy_reg <= 1'b0;
            mSampleDly_reg <= 1'b0;
            mDoneDly_reg <= 1'b0;
            sckOut_reg <= 1'b0;
        end else begin
            sr_reg <= sr_next;
            txOut_reg <= txOut_next;
            sckPrev_reg <= pinSync.sck;
            mSampleDly_reg <= mSample;
            mDoneDly_reg <= mDone && !modeFault;
            if (xferDone || idle) begin
                bitCnt_reg <= 4'h0;
            end else if (doSample) begin
                bitCnt_reg <= bitCnt_reg + 4'h1;
            end
            if (mStart) begin
                edgeCnt_reg <= 4'h0;
            end else if (tick) begin
                edgeCnt_reg <= edgeCnt_reg + 4'h1;
            end
            if (mStart) begin
                mBusy_reg <= 1'b1;
            end else if (mDone || modeFault || !isMaster) begin
                mBusy_reg <= 1'b0;
            end
            if (!mBusy_reg) begin
                sckOut_reg <= pol;
            end else if (tick) begin
                sckOut_reg <= !sckOut_reg;
            end
        end
    end

    // Status flags; a set in the same cycle as a clear wins.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            doneFlag_reg <= SSP_STAT_RESET[SSP_STAT_DONE];
            write_collision_flag_reg <= SSP_STAT_RESET[SSP_STAT_WRITE_COLLISION_FLAG];
            ovr_reg <= SSP_STAT_RESET[SSP_STAT_OVR];
            mode_fault_flag_reg <= SSP_STAT_RESET[SSP_STAT_MODE_FAULT_FLAG];
            armed_reg <= 1'b0;
            modfArmed_reg <= 1'b0;
            rxBuf_reg <= SSP_DATA_RESET;
        end else begin
            doneFlag_reg <= xferDone || (doneFlag_reg && !clrSeq);
            write_collision_flag_reg <= wcolSet || (write_collision_flag_reg && !clrSeq);
            ovr_reg <= (xferDone && doneFlag_reg) || (ovr_reg && !clrSeq);
            mode_fault_flag_reg <= modeFault || (mode_fault_flag_reg && !modfClr);
            armed_reg <= doneFlag_reg && !clrSeq && (armed_reg || statAcc);
            modfArmed_reg <= mode_fault_flag_reg && !modfClr && (modfArmed_reg || statAcc);
            // The shifter's next value holds the whole byte whichever edge samples last.
            if (xferDone && !doneFlag_reg) begin
                rxBuf_reg <= sr_next;
            end
        end
    end

    // Output drive; the serial output disable turns the port into receive only.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mOe_reg <= 1'b0;
            sOe_reg <= 1'b0;
            mosiOe_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            mOe_reg <= isMaster && !modeFault;
            sOe_reg <= sActive && !sod_reg;
            // The data drive has a flop of its own, so the pin needs no gate after it.
            // It follows a change of the disable bit one cycle late.
            mosiOe_reg <= isMaster && !modeFault && !sod_reg;
            irq_reg <= doneFlag_reg && irqEn && !cpuIrqMask;
        end
    end

    assign pinOut.sckOut = sckOut_reg;
    assign pinOut.sckOe = mOe_reg;
    assign pinOut.mosiOut = txOut_reg;
    assign pinOut.mosiOe = mosiOe_reg;
    assign pinOut.misoOut = txOut_reg;
    assign pinOut.misoOe = sOe_reg;
    assign rdData = rdData_reg;
    assign irqReq = irq_reg;
endmodule : ssp_core

/* File: pkg/ssp_pkg.sv */
// Shared constants, field positions and carrier types of the synchronous serial port.
package ssp_pkg;

    // Register offsets on the byte-wide register port.
    localparam logic [7:0] SSP_DATA_OFS = 8'h31;
    localparam logic [7:0] SSP_CTRL_OFS = 8'h32;
    localparam logic [7:0] SSP_STAT_OFS = 8'h33;

    // Values after reset.
    localparam logic [7:0] SSP_DATA_RESET = 8'h00;
    localparam logic [7:0] SSP_CTRL_RESET = 8'h00;
    localparam logic [7:0] SSP_STAT_RESET = 8'h00;

    // Fields of serial_control.
    localparam int SSP_CTRL_IRQ_EN = 7;
    localparam int SSP_CTRL_PERIPH_EN = 6;
    localparam int SSP_CTRL_RATE2 = 5;
    localparam int SSP_CTRL_MASTER = 4;
    localparam int SSP_CTRL_POL = 3;
    localparam int SSP_CTRL_PHA = 2;
    localparam int SSP_CTRL_RATE1 = 1;
    localparam int SSP_CTRL_RATE0 = 0;

    // Fields of serial_control_status.
    localparam int SSP_STAT_DONE = 7;
    localparam int SSP_STAT_WRITE_COLLISION_FLAG = 6;
    localparam int SSP_STAT_OVR = 5;
    localparam int SSP_STAT_MODE_FAULT_FLAG = 4;
    localparam int SSP_STAT_SOD = 2;
    localparam int SSP_STAT_SSM = 1;
    localparam int SSP_STAT_SSI = 0;
    localparam logic [7:0] SSP_STAT_WR_MASK = 8'h07;

    // Transfer geometry.
    localparam logic [3:0] SSP_LAST_BIT = 4'h7;
    localparam logic [3:0] SSP_LAST_EDGE = 4'hF;

    // Master clock: half period in CPU cycles for the fastest rate (f/4).
    localparam logic [6:0] SSP_HALF_MIN = 7'h02;
    localparam logic [2:0] SSP_RATE_MAX = 3'h5;

    typedef enum {SSP_OFF, SSP_MASTER, SSP_SLAVE} ssp_role_e;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ssN;
    } ssp_pin_in_s;

    typedef struct packed {
        logic sckOut;
        logic sckOe;
        logic mosiOut;
        logic mosiOe;
        logic misoOut;
        logic misoOe;
    } ssp_pin_out_s;

    // Six rates, f/4 up to f/128; the two spare codes fall back to the slowest.
    function automatic logic [6:0] ssp_half_period(input logic [2:0] rate);
        logic [2:0] r;
        r = (rate > SSP_RATE_MAX) ? SSP_RATE_MAX : rate;
        return SSP_HALF_MIN << r;
    endfunction : ssp_half_period

endpackage : ssp_pkg

/* File: rtl/ssp_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module ssp_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Asynchronous inputs and their synchronised copies.
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : ssp_sync

/* File: rtl/ssp_rate_div.sv */
// Master serial clock divider: one tick per half period of the selected rate.
`timescale 1ns/1ps
module ssp_rate_div (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Control.
    input wire logic run,
    input wire logic [2:0] rateSel,
    // Half period tick.
    output logic tick
);
    import ssp_pkg::*;

    logic [6:0] cnt_reg;
    wire [6:0] halfLast = ssp_half_period(rateSel) - 7'h01;
    wire atEnd = (cnt_reg == halfLast);

    // The count restarts whenever the master is idle, so a new byte's first edge
    // always comes a full half period after the data write.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 7'h00;
        end else if (!run || atEnd) begin
            cnt_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_reg + 7'h01;
        end
    end

    assign tick = run && atEnd;
endmodule : ssp_rate_div

/* File: test/ssp_core_properties.sv */
// Port-level checker of the serial port core, attached by bind.
`timescale 1ns/1ps
module ssp_core_properties
    import ssp_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Register port.
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    input wire logic [7:0] rdData,
    // Interrupt and pins.
    input wire logic cpuIrqMask,
    input wire logic irqReq,
    input wire ssp_pkg::ssp_pin_in_s pinIn,
    input wire ssp_pkg::ssp_pin_out_s pinOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    rd_idle_zero_a: assert property (!$past(rdStb) |-> rdData == 8'h00)
        else $error("read data not zero outside a read answer");
    rd_unmapped_a: assert property (rdStb && (addr < SSP_DATA_OFS || addr > SSP_STAT_OFS)
        |=> rdData == 8'h00) else $error("unmapped read not zero");
    // Master and enable bits may be dropped by a fault, so they are left out.
    ctrl_readback_a: assert property (
        wrStb && addr == SSP_CTRL_OFS ##2 rdStb && addr == SSP_CTRL_OFS
        |=> (rdData & 8'hAF) == ($past(wrData, 3) & 8'hAF)) else $error("control lost");
    irq_masked_a: assert property (cpuIrqMask |=> !irqReq)
        else $error("interrupt while masked");
    irq_hold_a: assert property (
        (!(wrStb || rdStb) && !cpuIrqMask)[*3] ##0 irqReq |=> irqReq)
        else $error("interrupt dropped without access");
    oe_excl_a: assert property (
        pinOut.misoOe |-> !pinOut.sckOe && !pinOut.mosiOe) else $error("role clash");
    mosi_sck_a: assert property (pinOut.mosiOe |-> pinOut.sckOe)
        else $error("data driven without clock");
    sck_half_min_a: assert property (
        pinOut.sckOe && $changed(pinOut.sckOut) |=> $stable(pinOut.sckOut))
        else $error("serial clock faster than quarter rate");
endmodule : ssp_core_properties

bind ssp_core ssp_core_properties i_props (.clk(clk), .rstn(rstn), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .cpuIrqMask(cpuIrqMask), .irqReq(irqReq), .pinIn(pinIn), .pinOut(pinOut));

/* File: test/ssp_partner.sv */
// Behavioural external serial slave in clock mode 0.
`timescale 1ns/1ps
module ssp_partner (
    // Frame select, high while addressed, and serial lines.
    input wire logic sel,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // Bytes out and in.
    input wire logic [7:0] txByte,
    output logic [7:0] rxByte
);
    logic [7:0] shiftReg = 8'h00;
    logic [2:0] bitCnt = 3'h0;
    initial begin
        miso = 1'b0;
        rxByte = 8'h00;
    end
    // A released line shows the inverse of its last level, never a stale bit.
    always @(posedge sel or negedge sel) begin
        shiftReg = txByte;
        bitCnt = 3'h0;
        miso = sel ? txByte[7] : ~miso;
    end
    always @(posedge sck) begin
        if (sel) begin
            shiftReg = {shiftReg[6:0], mosi};
            bitCnt = bitCnt + 3'h1;
            if (bitCnt == 3'h0) begin
                rxByte = shiftReg;
            end
        end
    end
    always @(negedge sck) begin
        if (sel) begin
            miso = shiftReg[7];
        end
    end
endmodule : ssp_partner

/* File: test/ssp_core_tb.sv */
// Self-checking testbench of the serial port core.
`timescale 1ns/1ps
module ssp_core_tb;
    import ssp_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wrData = 8'h00;
    logic wrStb = 1'b0;
    logic rdStb = 1'b0;
    logic [7:0] rdData;
    logic cpuIrqMask = 1'b0;
    logic irqReq;
    ssp_pin_in_s pinIn;
    ssp_pin_out_s pinOut;
    logic ssN = 1'b1;
    logic tbSck = 1'b0;
    logic tbMosi = 1'b0;
    logic partSel = 1'b0;
    logic partMiso;
    logic [7:0] txByte = 8'h00;
    logic [7:0] rxByte;
    int miscompares = 0;
    int checked = 0;
    // The clock line idles low when nobody drives it.
    assign pinIn = {pinOut.sckOe ? pinOut.sckOut : tbSck,
        pinOut.mosiOe ? pinOut.mosiOut : tbMosi,
        pinOut.misoOe ? pinOut.misoOut : partMiso, ssN};
    ssp_core i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .cpuIrqMask(cpuIrqMask), .irqReq(irqReq),
        .pinIn(pinIn), .pinOut(pinOut));
    ssp_partner i_part (.sel(partSel), .sck(pinIn.sck), .mosi(pinIn.mosi), .miso(partMiso),
        .txByte(txByte), .rxByte(rxByte));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    task automatic regWr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask : regWr
    task automatic regChk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 check(what, rdData, exp);
    endtask : regChk
    task automatic waitIrq(input int limit);
        int i;
        for (i = 0; i < limit && irqReq !== 1'b1; i++) begin
            @(posedge clk);
        end
        if (i == limit) begin
            miscompares++;
            $display("ERROR irqReq expected 1 seen timeout");
            summarize();
        end
    endtask : waitIrq
    // Full serial clock period in CPU cycles, high part plus low part.
    task automatic sckPeriod(output int n);
        int i;
        for (i = 0; i < 600 && pinOut.sckOut !== 1'b1; i++) @(posedge clk);
        for (i = 0; i < 600 && pinOut.sckOut === 1'b1; i++) @(posedge clk);
        for (n = i; n < 600 && pinOut.sckOut !== 1'b1; n++) @(posedge clk);
        if (n >= 600) begin
            miscompares++;
            $display("ERROR sckOut expected toggle seen timeout");
            summarize();
        end
    endtask : sckPeriod
    // The slave frame restarts so that the model reloads its reply byte.
    task automatic masterByte(input logic [2:0] r, input logic [7:0] d, input logic [7:0] back);
        partSel <= 1'b0;
        regWr(SSP_STAT_OFS, 8'h03);
        regWr(SSP_CTRL_OFS, {2'b11, r[2], 3'b100, r[1:0]});
        txByte <= back;
        partSel <= 1'b1;
        regWr(SSP_DATA_OFS, d);
    endtask : masterByte
    task automatic regReset();
        regChk("data reset", SSP_DATA_OFS, SSP_DATA_RESET);
        regChk("ctrl reset", SSP_CTRL_OFS, SSP_CTRL_RESET);
        regChk("status reset", SSP_STAT_OFS, SSP_STAT_RESET);
        regWr(8'h34, 8'hFF);
        regChk("unmapped", 8'h30, 8'h00);
        regWr(SSP_CTRL_OFS, 8'hAF);
        regChk("ctrl rw", SSP_CTRL_OFS, 8'hAF);
        regWr(SSP_STAT_OFS, 8'hFF);
        regChk("status rw", SSP_STAT_OFS, 8'h07);
        regWr(SSP_CTRL_OFS, 8'h00);
    endtask : regReset
    task automatic rateSweep();
        int p;
        for (int r = 0; r < 6; r++) begin
            masterByte(3'(r), 8'hA5 + 8'(r), 8'h3C + 8'(r));
            sckPeriod(p);
            check("sck period", 8'(p), 8'h04 << r);
            if (r == 0) begin
                regWr(SSP_DATA_OFS, 8'hFF);
            end
            waitIrq(64 << r);
            check("rx byte", rxByte, 8'hA5 + 8'(r));
            regChk("data early", SSP_DATA_OFS, 8'h3C + 8'(r));
            check("irq held", {7'h00, irqReq}, 8'h01);
            regChk("status", SSP_STAT_OFS, r == 0 ? 8'hC3 : 8'h83);
            regChk("data", SSP_DATA_OFS, 8'h3C + 8'(r));
            regChk("cleared", SSP_STAT_OFS, 8'h03);
        end
    endtask : rateSweep
    task automatic overrun();
        masterByte(3'h0, 8'h5A, 8'hC3);
        waitIrq(80);
        regWr(SSP_DATA_OFS, 8'h11);
        repeat (80) @(posedge clk);
        check("blocked", rxByte, 8'h5A);
        regChk("armed", SSP_STAT_OFS, 8'h83);
        regWr(SSP_DATA_OFS, 8'h22);
        repeat (80) @(posedge clk);
        check("second byte", rxByte, 8'h22);
        regChk("overrun", SSP_STAT_OFS, 8'hA3);
        regChk("old byte", SSP_DATA_OFS, 8'hC3);
        regChk("ovr clear", SSP_STAT_OFS, 8'h03);
    endtask : overrun
    task automatic modeFault();
        regWr(SSP_STAT_OFS, 8'h07);
        repeat (2) @(posedge clk);
        check("mosi released", {7'h00, pinOut.mosiOe}, 8'h00);
        check("sck kept", {7'h00, pinOut.sckOe}, 8'h01);
        regWr(SSP_STAT_OFS, 8'h00);
        regWr(SSP_CTRL_OFS, 8'h50);
        regChk("master kept", SSP_CTRL_OFS, 8'h50);
        ssN <= 1'b0;
        repeat (6) @(posedge clk);
        check("sck released", {7'h00, pinOut.sckOe}, 8'h00);
        regChk("fault", SSP_STAT_OFS, 8'h10);
        regChk("ctrl dropped", SSP_CTRL_OFS, 8'h00);
        regWr(SSP_CTRL_OFS, 8'h00);
        regChk("fault clear", SSP_STAT_OFS, 8'h00);
        ssN <= 1'b1;
    endtask : modeFault
    // The bench plays the remote master at one eighth of the CPU clock.
    task automatic slaveByte();
        logic [7:0] sent = 8'h69;
        logic [7:0] seen = 8'h00;
        regWr(SSP_CTRL_OFS, 8'hC0);
        regWr(SSP_DATA_OFS, 8'h96);
        ssN <= 1'b0;
        repeat (2) @(posedge clk);
        for (int b = 7; b >= 0; b--) begin
            tbMosi <= sent[b];
            repeat (4) @(posedge clk);
            seen[b] = pinIn.miso;
            tbSck <= 1'b1;
            repeat (4) @(posedge clk);
            tbSck <= 1'b0;
        end
        waitIrq(20);
        ssN <= 1'b1;
        check("miso byte", seen, 8'h96);
        cpuIrqMask <= 1'b1;
        repeat (2) @(posedge clk);
        check("irq masked", {7'h00, irqReq}, 8'h00);
        cpuIrqMask <= 1'b0;
        regChk("slave rx", SSP_DATA_OFS, 8'h69);
        regChk("slave done", SSP_STAT_OFS, 8'h80);
        regWr(SSP_DATA_OFS, 8'h00);
        regChk("slave clear", SSP_STAT_OFS, 8'h00);
    endtask : slaveByte
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        regReset();
        rateSweep();
        overrun();
        modeFault();
        slaveByte();
        summarize();
    end
endmodule : ssp_core_tb
